/* pkg/tws_pkg.sv */
// package: constants, states and carriers for the two-wire master transmit sequencer
package tws_pkg;

    // ----------------------------------------------------------------
    // status codes (prescaler bits are zero)
    // ----------------------------------------------------------------
    localparam logic [7:0] ST_IDLE = 8'hF8;          // nothing to report
    localparam logic [7:0] ST_START_SENT = 8'h08;    // start went out
    localparam logic [7:0] ST_ADDR_ACK = 8'h18;      // address sent, ack seen
    localparam logic [7:0] ST_ADDR_NACK = 8'h20;     // address sent, no ack
    localparam logic [7:0] ST_DATA_ACK = 8'h28;      // data sent, ack seen
    localparam logic [7:0] ST_DATA_NACK = 8'h30;     // data sent, no ack
    localparam logic [7:0] ST_STOP_ADDRESSED = 8'hA0; // stop or restart while addressed

    // ----------------------------------------------------------------
    // control word field positions
    // ----------------------------------------------------------------
    localparam int CTL_FLAG_BIT = 7;   // op_complete_flag
    localparam int CTL_ACK_BIT = 6;    // ack_enable
    localparam int CTL_START_BIT = 5;  // start_request
    localparam int CTL_STOP_BIT = 4;   // stop_request
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'hFF;

    // ----------------------------------------------------------------
    // timing: quarter of a bus bit period in link clock cycles
    // ----------------------------------------------------------------
    localparam int LINK_PERIOD_NS = 15;      // link clock period
    localparam int BIT_TIME_NS = 2400;       // one bus bit, least time
    localparam int QTR_CYCLES = (BIT_TIME_NS / 4 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

    // operations handed from the register side to the link side
    typedef enum logic [1:0] {
        TWS_OP_START,
        TWS_OP_BYTE,
        TWS_OP_STOP
    } tws_op_type;

    // one request crossing to the link
    typedef struct packed {
        tws_op_type op;
        logic [7:0] data;
    } tws_req_type;

    // one result crossing back
    typedef struct packed {
        logic ack;
        logic stop_seen;
    } tws_rsp_type;

endpackage

/* hdl/tws_master_tx.sv */
// two-wire master transmit sequencer; its addressed-stop response never fires, as addressed is never set
`timescale 1ns/10ps
`default_nettype none
// How it works
// (R1) writing one to flag clears it
// (R2) no bus operation while flag set
// (R3) release with start request sends START
// (R4) after START set flag, post start status
// (R5) one data register for address and data
// (R6) software loads address then releases flag
// (R7) release after address load shifts address out
// (R8) after address set flag, status shows ack
// (R9) software checks status before loading data
// (R10) release with data sends it, reports ack
// (R11) status 0xA0 on stop while addressed; addressed is never set here, so the code never posts it
// (R12) release without ack: ignore own and general
// (R13) release with ack: own, general if enabled
// (R14) release with start: START once bus free
// (R15) software masks prescaler bits in status
module tws_master_tx (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic ctl_write,
    input wire logic [7:0] ctl_wdata,
    input wire logic data_write,
    input wire logic [7:0] data_wdata,
    input wire logic general_call_enable,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    output logic op_complete_flag,
    output logic [7:0] bus_status_reg,
    output logic [7:0] bus_data_reg,
    output logic own_address_enable,
    output logic general_call_listen
);
    // ----------------------------------------------------------------
    // register side state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_ADDR, SEQ_DATA} seq_type;
    seq_type phase, next_phase;                 // which step was issued last
    logic flag, next_flag;                      // op_complete_flag
    logic [7:0] status, next_status;            // bus_status_reg
    logic [7:0] data, next_data;                // bus_data_reg
    logic addressed, next_addressed;            // addressed as slave receiver
    logic own_en, next_own_en;                  // own address recognised
    logic gc_en, next_gc_en;                    // general call recognised
    logic pend_start, next_pend_start;          // start waits for free bus
    logic req_tgl, next_req_tgl;                // request toggle to link
    tws_pkg::tws_req_type req, next_req;        // request held stable
    logic busy, next_busy;                      // request outstanding
    // link side results synchronised in
    logic [2:0] done_sync; // done toggle chain
    logic [1:0] free_sync; // bus free level
    logic [2:0] stop_sync; // stop-seen toggle chain
    logic done_ev, stop_ev; // one-cycle events
    // ----------------------------------------------------------------
    // link side state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {LK_IDLE, LK_START, LK_BIT, LK_ACK, LK_STOP} lk_type;
    lk_type lk, next_lk;                        // link sequencer
    logic rq_s1, rq_s2, rq_seen, next_rq_seen;  // request toggle sync
    logic done_tgl, next_done_tgl;              // completion toggle
    logic [7:0] shreg, next_shreg;              // shift register
    logic [2:0] bitn, next_bitn;                // bit index
    logic [1:0] qtr, next_qtr;                  // quarter of bit
    logic [15:0] cnt, next_cnt;                 // quarter counter
    logic scl_q, next_scl_q, sda_q, next_sda_q; // pin drive, low when set
    logic ack_q, next_ack_q;                    // sampled acknowledge
    logic [1:0] scl_sync; // clock pin synchroniser
    logic [2:0] sda_sync; // data pin synchroniser, third stage for edges
    logic busfree, next_busfree;                // no frame on the bus
    logic stop_tgl, next_stop_tgl;              // stop seen toggle
    logic lk_busy;                              // our own start, byte or stop operation in progress
    // ----------------------------------------------------------------
    // register side crossing
    // ----------------------------------------------------------------
    // toggles from the link domain become one-cycle events; ack_q is stable from done on
    assign done_ev = done_sync[1] ^ done_sync[2];
    assign stop_ev = stop_sync[1] ^ stop_sync[2];
    // ----------------------------------------------------------------
    // register side sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_phase = phase;
        next_flag = flag;
        next_status = status;
        next_data = data;
        next_addressed = addressed;
        next_own_en = own_en;
        next_gc_en = gc_en;
        next_pend_start = pend_start;
        next_req_tgl = req_tgl;
        next_req = req;
        next_busy = busy;
        // shared register for address and data
        if (data_write) begin
            next_data = data_wdata; // (R5)
        end
        // release: a one in the flag bit clears it; the first start goes from idle
        if (ctl_write && ctl_wdata[tws_pkg::CTL_FLAG_BIT] && !busy
            && (flag || status == tws_pkg::ST_IDLE)) begin
            next_flag = 1'b0; // (R1)
            if (status == tws_pkg::ST_STOP_ADDRESSED) begin
                // leave addressed state, pick recognition
                next_addressed = 1'b0;
                next_own_en = ctl_wdata[tws_pkg::CTL_ACK_BIT]; // (R12) (R13)
                next_gc_en = ctl_wdata[tws_pkg::CTL_ACK_BIT] && general_call_enable; // (R13)
                next_pend_start = ctl_wdata[tws_pkg::CTL_START_BIT]; // (R14)
                next_status = tws_pkg::ST_IDLE;
            end else begin
                next_req_tgl = ~req_tgl;
                next_busy = 1'b1;
                if (ctl_wdata[tws_pkg::CTL_STOP_BIT]) begin
                    next_req.op = tws_pkg::TWS_OP_STOP;
                    next_phase = SEQ_IDLE;
                end else if (ctl_wdata[tws_pkg::CTL_START_BIT] || phase == SEQ_IDLE) begin
                    next_req.op = tws_pkg::TWS_OP_START; // (R3)
                    next_phase = SEQ_START;
                end else begin
                    // address or data byte from the shared register
                    next_req.op = tws_pkg::TWS_OP_BYTE; // (R7) (R10)
                    next_req.data = data_write ? data_wdata : data;
                    next_phase = (phase == SEQ_START) ? SEQ_ADDR : SEQ_DATA;
                end
            end
        end
        // a deferred start leaves once the bus is free
        if (pend_start && free_sync[1] && !busy && !flag) begin
            next_pend_start = 1'b0;
            next_req.op = tws_pkg::TWS_OP_START; // (R14)
            next_req_tgl = ~req_tgl;
            next_busy = 1'b1;
            next_phase = SEQ_START;
        end
        // completion of a link operation
        if (done_ev) begin
            next_busy = 1'b0;
            if (req.op != tws_pkg::TWS_OP_STOP) begin
                next_flag = 1'b1; // (R4) (R8) (R10)
            end
            case (phase)
                SEQ_START: next_status = tws_pkg::ST_START_SENT; // (R4)
                SEQ_ADDR: next_status = ack_q ? tws_pkg::ST_ADDR_ACK
                                                : tws_pkg::ST_ADDR_NACK; // (R8)
                SEQ_DATA: next_status = ack_q ? tws_pkg::ST_DATA_ACK
                                                : tws_pkg::ST_DATA_NACK; // (R10)
                default: next_status = tws_pkg::ST_IDLE;
            endcase
        end
        // stop seen on the bus while still addressed as a receiver
        if (stop_ev && addressed) begin
            next_flag = 1'b1;
            next_status = tws_pkg::ST_STOP_ADDRESSED; // (R11)
        end
    end
    // sequencer registers and the synchronisers from the link domain
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= SEQ_IDLE;
            flag <= 1'b0;
            status <= tws_pkg::ST_IDLE;
            data <= tws_pkg::DATA_RESET;
            addressed <= 1'b0;
            own_en <= 1'b0;
            gc_en <= 1'b0;
            pend_start <= 1'b0;
            req_tgl <= 1'b0;
            req <= '0;
            busy <= 1'b0;
            done_sync <= 3'h0;
            free_sync <= 2'h3;
            stop_sync <= 3'h0;
        end else begin
            phase <= next_phase;
            flag <= next_flag;
            status <= next_status;
            data <= next_data;
            addressed <= next_addressed;
            own_en <= next_own_en;
            gc_en <= next_gc_en;
            pend_start <= next_pend_start;
            req_tgl <= next_req_tgl;
            req <= next_req;
            busy <= next_busy;
            done_sync <= {done_sync[1:0], done_tgl};
            free_sync <= {free_sync[0], busfree};
            stop_sync <= {stop_sync[1:0], stop_tgl};
        end
    end
    // outputs straight from flops
    assign op_complete_flag = flag;
    assign bus_status_reg = status;
    assign bus_data_reg = data;
    assign own_address_enable = own_en;
    assign general_call_listen = gc_en;
    // ----------------------------------------------------------------
    // link side
    // ----------------------------------------------------------------
    assign lk_busy = (lk != LK_IDLE);
    always_comb begin
        next_lk = lk;
        next_rq_seen = rq_seen;
        next_done_tgl = done_tgl;
        next_shreg = shreg;
        next_bitn = bitn;
        next_qtr = qtr;
        next_cnt = cnt;
        next_scl_q = scl_q;
        next_sda_q = sda_q;
        next_ack_q = ack_q;
        next_busfree = busfree;
        next_stop_tgl = stop_tgl;
        // watch for start and stop made by anyone
        if (scl_sync[1] && sda_sync[2] && !sda_sync[1]) begin
            next_busfree = 1'b0;
        end
        if (scl_sync[1] && !sda_sync[2] && sda_sync[1]) begin
            next_busfree = 1'b1;
            next_stop_tgl = ~stop_tgl;
        end
        // quarter-bit timebase
        if (lk_busy) begin
            next_cnt = cnt + 16'h0001;
        end
        if (lk_busy && cnt == 16'(tws_pkg::QTR_CYCLES - 1)) begin
            next_cnt = 16'h0000;
            next_qtr = qtr + 2'h1;
        end
        case (lk)
            LK_IDLE: begin
                // take a new request
                if (rq_s2 != rq_seen) begin // (R2)
                    next_rq_seen = rq_s2;
                    next_cnt = 16'h0000;
                    next_qtr = 2'h0;
                    next_shreg = req.data;
                    next_bitn = 3'h7;
                    case (req.op)
                        tws_pkg::TWS_OP_START: next_lk = LK_START; // (R3)
                        tws_pkg::TWS_OP_BYTE: next_lk = LK_BIT; // (R7) (R10)
                        default: next_lk = LK_STOP;
                    endcase
                end
            end
            LK_START: begin
                // data low with clock high, then clock low
                if (next_qtr == 2'h0 && qtr == 2'h3) begin
                    next_scl_q = 1'b1;
                    next_lk = LK_IDLE;
                    next_done_tgl = ~done_tgl; // (R4)
                end else begin
                    next_sda_q = (qtr >= 2'h2);
                    next_scl_q = 1'b0;
                end
            end
            LK_BIT: begin
                // data moves with clock low
                next_sda_q = ~shreg[bitn];
                next_scl_q = (qtr == 2'h0) || (qtr == 2'h3);
                if (next_qtr == 2'h0 && qtr == 2'h3) begin
                    next_bitn = bitn - 3'h1;
                    if (bitn == 3'h0) begin
                        next_lk = LK_ACK;
                    end
                end
            end
            LK_ACK: begin
                // release data, sample ack
                next_sda_q = 1'b0;
                next_scl_q = (qtr == 2'h0) || (qtr == 2'h3);
                if (qtr == 2'h2 && cnt == 16'h0000) begin
                    next_ack_q = ~sda_sync[1]; // (R8) (R10)
                end
                if (next_qtr == 2'h0 && qtr == 2'h3) begin
                    next_lk = LK_IDLE;
                    next_done_tgl = ~done_tgl;
                end
            end
            LK_STOP: begin
                // data low, clock up, then data up
                next_scl_q = (qtr == 2'h0);
                next_sda_q = (qtr <= 2'h1);
                if (next_qtr == 2'h0 && qtr == 2'h3) begin
                    next_scl_q = 1'b0;
                    next_sda_q = 1'b0;
                    next_lk = LK_IDLE;
                    next_done_tgl = ~done_tgl;
                end
            end
            default: next_lk = LK_IDLE;
        endcase
    end
    // link registers and pin synchronisers
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lk <= LK_IDLE;
            rq_s1 <= 1'b0;
            rq_s2 <= 1'b0;
            rq_seen <= 1'b0;
            done_tgl <= 1'b0;
            shreg <= 8'h00;
            bitn <= 3'h7;
            qtr <= 2'h0;
            cnt <= 16'h0000;
            scl_q <= 1'b0;
            sda_q <= 1'b0;
            ack_q <= 1'b0;
            scl_sync <= 2'h3;
            sda_sync <= 3'h7;
            busfree <= 1'b1;
            stop_tgl <= 1'b0;
        end else begin
            lk <= next_lk;
            rq_s1 <= req_tgl;
            rq_s2 <= rq_s1;
            rq_seen <= next_rq_seen;
            done_tgl <= next_done_tgl;
            shreg <= next_shreg;
            bitn <= next_bitn;
            qtr <= next_qtr;
            cnt <= next_cnt;
            scl_q <= next_scl_q;
            sda_q <= next_sda_q;
            ack_q <= next_ack_q;
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            busfree <= next_busfree;
            stop_tgl <= next_stop_tgl;
        end
    end
    // open drain: only ever drive low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = scl_q;
    assign sda_oe = sda_q;
endmodule
`default_nettype wire

/* testbench/tws_master_tx_checker.sv */
// checker: port-level assertions
`timescale 1ns/10ps
`default_nettype none
module tws_master_tx_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic ctl_write,
    input wire logic [7:0] ctl_wdata,
    input wire logic data_write,
    input wire logic [7:0] data_wdata,
    input wire logic general_call_enable,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic op_complete_flag,
    input wire logic [7:0] bus_status_reg,
    input wire logic [7:0] bus_data_reg,
    input wire logic own_address_enable,
    input wire logic general_call_listen
);
    // ----------------------------------------------------------------
    // helper state
    // ----------------------------------------------------------------
    logic rel; // release write
    logic rel_ok; // release taken
    logic [1:0] kind, next_kind; // 1 start, 2 byte, 3 stop
    logic addr_phase, next_addr_phase; // address byte
    logic [15:0] wait_cnt, next_wait_cnt; // wait for flag
    assign rel = ctl_write && ctl_wdata[7];
    assign rel_ok = rel && (op_complete_flag || bus_status_reg == tws_pkg::ST_IDLE);
    // next helper values
    always_comb begin
        next_kind = kind;
        next_addr_phase = addr_phase;
        next_wait_cnt = wait_cnt;
        if (rel_ok) begin
            next_kind = ctl_wdata[5] ? 2'd1 : (ctl_wdata[4] ? 2'd3 : 2'd2);
            next_addr_phase = !ctl_wdata[5] && !ctl_wdata[4] && kind == 2'd1;
            next_wait_cnt = 16'h0000;
        end else if (!op_complete_flag && (kind == 2'd1 || kind == 2'd2)) begin
            next_wait_cnt = wait_cnt + 16'h0001;
        end
    end
    // helper registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            kind <= 2'd0;
            addr_phase <= 1'b0;
            wait_cnt <= 16'h0000;
        end else begin
            kind <= next_kind;
            addr_phase <= next_addr_phase;
            wait_cnt <= next_wait_cnt;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // start: data low, clock released
    sequence s_start_edge;
        $rose(sda_oe) && !scl_oe;
    endsequence
    sequence s_flag_up;
        $rose(op_complete_flag);
    endsequence
    a_flag_write_clear: assert property (op_complete_flag && rel |=> !op_complete_flag)
        else $error("flag not cleared");
    a_flag_holds_set: assert property (op_complete_flag && !rel |=> op_complete_flag)
        else $error("flag dropped");
    a_bus_quiet_flag: assert property (op_complete_flag && $past(op_complete_flag)
        |-> $stable(scl_oe) && $stable(sda_oe))
        else $error("bus moved while flag set");
    a_start_goes_out: assert property (rel_ok && ctl_wdata[5] && !ctl_wdata[4]
        |-> ##[1:1000] s_start_edge)
        else $error("no start");
    a_start_code: assert property (s_flag_up and kind == 2'd1
        |-> bus_status_reg == tws_pkg::ST_START_SENT)
        else $error("bad start status");
    a_data_load: assert property (data_write && op_complete_flag
        |=> bus_data_reg == $past(data_wdata))
        else $error("data not loaded");
    a_byte_moves: assert property (rel_ok && !ctl_wdata[5] && !ctl_wdata[4]
        && bus_status_reg != tws_pkg::ST_STOP_ADDRESSED |-> ##[1:1000] !scl_oe)
        else $error("byte not shifted");
    a_addr_code: assert property (s_flag_up and kind == 2'd2 && addr_phase
        |-> bus_status_reg inside {tws_pkg::ST_ADDR_ACK, tws_pkg::ST_ADDR_NACK})
        else $error("bad address status");
    a_data_code: assert property (s_flag_up and kind == 2'd2 && !addr_phase
        |-> bus_status_reg inside {tws_pkg::ST_DATA_ACK, tws_pkg::ST_DATA_NACK})
        else $error("bad data status");
    a_done_bounded: assert property (wait_cnt < 16'd8000)
        else $error("operation hung");
    a_listen_update: assert property (rel && op_complete_flag
        && bus_status_reg == tws_pkg::ST_STOP_ADDRESSED |=> own_address_enable == $past(ctl_wdata[6])
        && general_call_listen == ($past(ctl_wdata[6]) && $past(general_call_enable)))
        else $error("bad listen enables");
endmodule
bind tws_master_tx tws_master_tx_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .link_clk(link_clk), .ctl_write(ctl_write), .ctl_wdata(ctl_wdata),
    .data_write(data_write), .data_wdata(data_wdata), .general_call_enable(general_call_enable),
    .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .op_complete_flag(op_complete_flag), .bus_status_reg(bus_status_reg),
    .bus_data_reg(bus_data_reg), .own_address_enable(own_address_enable),
    .general_call_listen(general_call_listen));
`default_nettype wire

/* testbench/tws_bus_slave.sv */
// bus slave model: counts starts and stops, takes bytes, acks
`timescale 1ns/10ps
`default_nettype none
module tws_bus_slave (
    input wire logic scl,
    input wire logic sda,
    input wire logic ack_on,
    output var logic sda_oe,
    output var logic [7:0] last_byte,
    output var logic [7:0] start_cnt,
    output var logic [7:0] stop_cnt
);
    logic [7:0] shreg = 8'h00; // incoming bits, msb first
    int bit_cnt = 0; // bits taken in the current byte
    logic acking = 1'b0; // inside the acknowledge bit
    initial begin
        sda_oe = 1'b0;
        last_byte = 8'h00;
        start_cnt = 8'h00;
        stop_cnt = 8'h00;
    end
    // start: data falls with clock high; time zero settling ignored
    always @(negedge sda) begin
        if (scl === 1'b1 && $time > 0) begin
            start_cnt = start_cnt + 8'h01;
            bit_cnt = 0;
            acking = 1'b0;
        end
    end
    // stop: data rises while the clock is high
    always @(posedge sda) begin
        if (scl === 1'b1 && $time > 0) begin
            stop_cnt = stop_cnt + 8'h01;
        end
    end
    // take data bits on rising clock
    always @(posedge scl) begin
        if (!acking && bit_cnt < 8) begin
            shreg = {shreg[6:0], sda};
            bit_cnt = bit_cnt + 1;
        end
    end
    // ack in the ninth bit when asked
    always @(negedge scl) begin
        if (acking) begin
            acking = 1'b0;
            sda_oe = 1'b0;
            bit_cnt = 0;
        end else if (bit_cnt == 8) begin
            acking = 1'b1;
            last_byte = shreg;
            sda_oe = ack_on;
        end
    end
endmodule
`default_nettype wire

/* testbench/two_wire_master_tx_sequencer_tb.sv */
// testbench: start, address, data and stop steps
`timescale 1ns/10ps
`default_nettype none
module two_wire_master_tx_sequencer_tb;
    logic ref_clk, link_clk, rst_n, ctl_write, data_write, general_call_enable, ack_on;
    logic [7:0] ctl_wdata, data_wdata, bus_status_reg, bus_data_reg;
    logic scl_out, scl_oe, sda_out, sda_oe, op_complete_flag, own_address_enable;
    logic general_call_listen, slave_oe, scl_line, sda_line;
    logic [7:0] last_byte, start_cnt, stop_cnt; // what the slave saw
    int num_errors = 0;
    int samples_checked = 0;
    logic [7:0] bytes [4] = '{8'h5B, 8'hC3, 8'h00, 8'hFF}; // data table
    logic acks [4] = '{1'b1, 1'b0, 1'b1, 1'b1}; // slave answer per byte
    // open-drain lines with pull-ups
    assign scl_line = !scl_oe;
    assign sda_line = !(sda_oe || slave_oe);
    tws_master_tx u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
        .ctl_write(ctl_write), .ctl_wdata(ctl_wdata), .data_write(data_write),
        .data_wdata(data_wdata), .general_call_enable(general_call_enable), .scl_in(scl_line),
        .sda_in(sda_line), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
        .op_complete_flag(op_complete_flag), .bus_status_reg(bus_status_reg),
        .bus_data_reg(bus_data_reg), .own_address_enable(own_address_enable),
        .general_call_listen(general_call_listen));
    tws_bus_slave u_slave (.scl(scl_line), .sda(sda_line), .ack_on(ack_on), .sda_oe(slave_oe),
        .last_byte(last_byte), .start_cnt(start_cnt), .stop_cnt(stop_cnt));
    // clocks: 4 ns system, 15 ns link
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle write pulse
    task automatic wr(input logic is_ctl, input logic [7:0] w);
        @(posedge ref_clk);
        #1;
        ctl_write = is_ctl;
        data_write = !is_ctl;
        ctl_wdata = w;
        data_wdata = w;
        @(posedge ref_clk);
        #1;
        ctl_write = 1'b0;
        data_write = 1'b0;
    endtask
    // release, wait for the flag, judge masked status
    task automatic op(input logic [7:0] w, input logic [7:0] code);
        int n;
        wr(1'b1, w);
        check("flag cleared", {7'h00, op_complete_flag}, 8'h00);
        n = 0;
        while (op_complete_flag !== 1'b1 && n < 20000) begin
            @(posedge ref_clk);
            n++;
        end
        #1;
        check("flag set", {7'h00, op_complete_flag}, 8'h01);
        check("status", bus_status_reg & 8'hF8, code);
    endtask
    task automatic t_reset;
        check("reset flag", {7'h00, op_complete_flag}, 8'h00);
        check("reset status", bus_status_reg, tws_pkg::ST_IDLE);
        check("reset data", bus_data_reg, tws_pkg::DATA_RESET);
        check("reset oe", {6'h00, scl_oe, sda_oe}, 8'h00);
    endtask
    task automatic t_start_then_hold;
        op(8'hA0, tws_pkg::ST_START_SENT);
        check("starts", start_cnt, 8'h01);
        wr(1'b1, 8'h20); // no flag bit
        wr(1'b1, 8'h60);
        repeat (400) @(posedge ref_clk);
        check("flag held", {7'h00, op_complete_flag}, 8'h01);
        check("no new start", start_cnt, 8'h01);
        check("status held", bus_status_reg, tws_pkg::ST_START_SENT);
    endtask
    task automatic t_address_and_data;
        ack_on = 1'b1;
        wr(1'b0, 8'hA4);
        check("addr loaded", bus_data_reg, 8'hA4);
        op(8'h80, tws_pkg::ST_ADDR_ACK);
        check("addr on bus", last_byte, 8'hA4);
        for (int i = 0; i < 4; i++) begin
            ack_on = acks[i];
            wr(1'b0, bytes[i]);
            check("data loaded", bus_data_reg, bytes[i]);
            op(8'h80, acks[i] ? tws_pkg::ST_DATA_ACK : tws_pkg::ST_DATA_NACK);
            check("data on bus", last_byte, bytes[i]);
        end
    endtask
    task automatic t_restart_nack_stop;
        int n;
        op(8'hA0, tws_pkg::ST_START_SENT);
        check("restart", start_cnt, 8'h02);
        ack_on = 1'b0;
        wr(1'b0, 8'hA6);
        op(8'h80, tws_pkg::ST_ADDR_NACK);
        check("nack addr", last_byte, 8'hA6);
        wr(1'b1, 8'h90);
        n = 0;
        while (stop_cnt !== 8'h01 && n < 20000) begin
            @(posedge ref_clk);
            n++;
        end
        check("stop seen", stop_cnt, 8'h01);
        check("flag after stop", {7'h00, op_complete_flag}, 8'h00);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        ctl_write = 1'b0;
        ctl_wdata = 8'h00;
        data_write = 1'b0;
        data_wdata = 8'h00;
        general_call_enable = 1'b0;
        ack_on = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        repeat (2) @(posedge ref_clk);
        t_start_then_hold();
        t_address_and_data();
        t_restart_nack_stop();
        conclude();
    end
    // watchdog
    initial begin
        repeat (100000) @(posedge ref_clk);
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
